// ---- sync_serial_module.v ----
// Synchronous serial port: SPI master and slave, two-wire master sequencer, AHB-Lite registers.
`timescale 1ns/1ps
`include "ssp_defines.vh"
// Bus side: every register is one byte in the low lane of a word; the buffer and sequence control offsets 13h and 91h are unaligned.
// The slave never inserts wait states, so a transfer takes one address cycle and one data cycle.
// Read data is chosen from the address phase and registered at its closing edge.
// That way the word already stands on the bus while the data phase runs.
// Write data is taken at the closing edge of the data phase, as the bus protocol places it there.
// A read whose address phase overlaps a write's data phase to the same register therefore sees the old value.
// Pin side: every pin input passes two flip-flops before any logic reads it.
// The serial clock pin is then edge-detected against a third copy.
// An edge on the pin is seen two to three core cycles after it happens.
// Data pins pass through the same two flops and keep the same delay.
// A peer must hold its data for several core cycles around each clock edge.
// The master clock is derived from the core clock or the timer tick input.
// At the fastest divider a half period is only two core cycles long.
// Incoming data then reaches the shift register later than the sampling edge.
// Users who need reliable master reception should pick a slower divider.
// Sleep stops the master dividers and the two-wire sequencer where they stand.
// The slave shifter keeps running from the pin clock while the core sleeps.
// A finished slave byte raises the done flag and, if unmasked, the wake output.
// Disabling the port drops any transfer in progress and releases the clock and two-wire pins; SDO has no enable and stays driven.
// The interrupt status register is sticky; writing a one clears a bit.
// An event in the same cycle as its clear keeps the bit set.
// Behaviour
// - Received byte moves to buffer, sets flag.
// - Buffer write loads shift register too.
// - Status low six bits read-only.
// - Shift register has no address.
// - Master freezes during sleep, then resumes.
// - Slave shifts on external clock while sleeping.
// - Slave sets flag after 8 bits; wakes.
// - Reset disables port, abandons transfer.
// - SPI modes map onto polarity and edge in the slave; the master uses polarity only, with fixed edges.
// - Acknowledge status reads 1 when not acknowledged.
// - Repeated-start request makes condition, self-clears.
// - Start request makes condition, self-clears.
// - Non-idle two-wire ignores requests, blocks writes.
module sync_serial_module (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  input  wire        SCK_IN,
  output reg         SCK_OUT,
  output reg         SCK_OE_N,
  input  wire        SDI,
  output reg         SDO,
  input  wire        SEL_N,
  input  wire        TMR_TICK,
  input  wire        SDA_IN,
  output reg         SDA_OUT,
  output reg         SDA_OE_N,
  output reg         SCL_OUT,
  output reg         SCL_OE_N,
  output reg         IRQ,
  output reg         WAKE
);
  localparam [3:0] TW_IDLE = 4'h1;
  localparam [3:0] TW_A    = 4'h2;
  localparam [3:0] TW_B    = 4'h4;
  localparam [3:0] TW_ACK  = 4'h8;

  // Software-visible registers and the hidden shift register.
  reg  [7:0] ctl_q;  // Control: collision, overflow, enable, polarity, mode.
  reg  [7:0] stat_q; // Status: sample phase, edge select, buffer full.
  reg  [7:0] buf_q;  // Data buffer seen by software.
  reg  [7:0] sr_q;   // Shift register, reachable only through the buffer.
  reg  [7:0] seq_q;  // Two-wire sequence requests and acknowledge status.
  reg  [7:0] irq_q;  // Sticky event flags.
  reg  [7:0] mask_q; // Interrupt enables, same layout as the flags.
  reg        sleep_q, busy_q;
  reg  [3:0] cnt_q;
  reg  [5:0] div_q;
  reg  [1:0] sck_s, sdi_s, sel_s, sda_s, tmr_s;
  reg        sck_d1, tmr_d1;
  reg  [3:0] tw_q;
  reg  [7:0] tw_cnt_q;
  reg  [3:0] tw_op_q;
  reg        ph_wr, ph_sel;
  reg  [7:0] ph_adr;
  wire [3:0] mode       = ctl_q[3:0];
  wire       en         = ctl_q[`CTL_EN];
  wire       clock_polarity_select        = ctl_q[`CTL_CKP];
  wire       cke        = stat_q[`STAT_CKE];
  wire       is_master  = en && (mode <= `MODE_M_TMR);
  wire       is_slave   = en && (mode == `MODE_S_SEL || mode == `MODE_S_NOSEL);
  wire       is_tw      = en && (mode == `MODE_TW_MASTER);
  wire       tw_idle    = (tw_q == TW_IDLE);
  wire       sel_ok     = (mode == `MODE_S_NOSEL) || !sel_s[1];
  wire       sck_rise   = sck_s[1] && !sck_d1;
  wire       sck_fall   = !sck_s[1] && sck_d1;
  // Transmit edge is active-to-idle when edge select is 1, giving the standard mode map.
  wire       lead_e     = (clock_polarity_select ^ cke) ? sck_fall : sck_rise;
  wire       trail_e    = (clock_polarity_select ^ cke) ? sck_rise : sck_fall;
  wire       tmr_tick   = tmr_s[1] && !tmr_d1;
  wire       acc        = HSEL && HREADY && HTRANS[1];
  wire       wr_buf     = ph_sel && ph_wr && ph_adr == `OFS_BUFFER;
  wire       wr_ctl     = ph_sel && ph_wr && ph_adr == `OFS_CONTROL;
  wire       rd_buf     = ph_sel && !ph_wr && ph_adr == `OFS_BUFFER;
  reg        half_tick;
  reg  [7:0] rdata;

  // Master half-period tick from the selected clock source; none while asleep.
  always @* begin
    case (mode)
      `MODE_M_DIV4:  half_tick = (div_q[0] == 1'b1);
      `MODE_M_DIV16: half_tick = (div_q[2:0] == 3'h7);
      `MODE_M_DIV64: half_tick = (div_q[4:0] == 5'h1F);
      default:       half_tick = tmr_tick;
    endcase
    half_tick = half_tick && is_master && busy_q && !sleep_q;
  end

  // Register read multiplexer; the shift register has no address.
  // It decodes the address-phase address so that the registered read word
  // stands on the bus for the whole data phase, with no wait state.
  always @* begin
    case (HADDR[7:0])
      `OFS_CONTROL:     rdata = ctl_q;
      `OFS_STATUS:      rdata = stat_q;
      `OFS_BUFFER:      rdata = buf_q;
      `OFS_SEQ_CONTROL: rdata = seq_q;
      `OFS_IRQ_STATUS:  rdata = irq_q;
      `OFS_IRQ_MASK:    rdata = mask_q;
      `OFS_SLEEP:       rdata = {7'h00, sleep_q};
      default:          rdata = 8'h00;
    endcase
  end

  // Pin synchronisers: two flops before any use.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_s  <= 2'h0;
      sdi_s  <= 2'h0;
      sel_s  <= 2'h3;
      sda_s  <= 2'h3;
      tmr_s  <= 2'h0;
      sck_d1 <= 1'b0;
      tmr_d1 <= 1'b0;
    end else begin
      sck_s  <= {sck_s[0], SCK_IN};
      sdi_s  <= {sdi_s[0], SDI};
      sel_s  <= {sel_s[0], SEL_N};
      sda_s  <= {sda_s[0], SDA_IN};
      tmr_s  <= {tmr_s[0], TMR_TICK};
      sck_d1 <= sck_s[1];
      tmr_d1 <= tmr_s[1];
    end
  end

  // Bus slave: one wait-free data phase, always OKAY.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ph_sel    <= 1'b0;
      ph_wr     <= 1'b0;
      ph_adr    <= 8'h00;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      ph_sel    <= acc;
      ph_wr     <= HWRITE;
      ph_adr    <= HADDR[7:0];
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      // Capture the read word at the end of the address phase; zero otherwise.
      if (acc && !HWRITE)
        HRDATA <= {24'h00_0000, rdata};
      else
        HRDATA <= 32'h0000_0000;
    end
  end

  // Registers, SPI engine and two-wire sequencer share one process.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl_q    <= `CTL_RESET;
      stat_q   <= `STAT_RESET;
      buf_q    <= 8'h00;
      sr_q     <= 8'h00;
      seq_q    <= 8'h00;
      irq_q    <= 8'h00;
      mask_q   <= 8'h00;
      sleep_q  <= 1'b0;
      busy_q   <= 1'b0;
      cnt_q    <= 4'h0;
      div_q    <= 6'h00;
      tw_q     <= TW_IDLE;
      tw_cnt_q <= 8'h00;
      tw_op_q  <= 4'h0;
      SCK_OUT  <= 1'b0;
      SCK_OE_N <= 1'b1;
      SDO      <= 1'b0;
      SDA_OUT  <= 1'b0;
      SDA_OE_N <= 1'b1;
      SCL_OUT  <= 1'b0;
      SCL_OE_N <= 1'b1;
      IRQ      <= 1'b0;
      WAKE     <= 1'b0;
    end else begin
      div_q <= sleep_q ? div_q : div_q + 6'h01;
      // Software writes; the data-phase word is taken here.
      if (wr_ctl) begin
        ctl_q[6:0] <= HWDATA[6:0];
        // A new mode starts from a clean bit count, whatever the old mode left.
        cnt_q      <= 4'h0;
        if (!HWDATA[`CTL_WRITE_COLLISION_FLAG])
          ctl_q[`CTL_WRITE_COLLISION_FLAG] <= 1'b0;
        if (!HWDATA[`CTL_EN]) begin
          busy_q <= 1'b0;
          tw_q   <= TW_IDLE;
        end
      end
      if (ph_sel && ph_wr && ph_adr == `OFS_STATUS)
        stat_q[7:6] <= HWDATA[7:6];
      if (ph_sel && ph_wr && ph_adr == `OFS_IRQ_MASK)
        mask_q <= HWDATA[7:0];
      if (ph_sel && ph_wr && ph_adr == `OFS_SLEEP)
        sleep_q <= HWDATA[0];
      if (ph_sel && ph_wr && ph_adr == `OFS_SEQ_CONTROL) begin
        seq_q[7] <= HWDATA[7];
        seq_q[5] <= HWDATA[5];
        if (tw_idle && is_tw) begin
          seq_q[4:0] <= HWDATA[4:0];
          tw_op_q    <= HWDATA[`SEQ_ACK_SEQUENCE_REQUEST] ? 4'h4 : HWDATA[`SEQ_RECEIVE_REQUEST] ? 4'h3 :
                        HWDATA[`SEQ_PEN] ? 4'h2 : HWDATA[`SEQ_REPEAT_START_REQUEST] ? 4'h1 : 4'h0;
          if (HWDATA[4:0] != 5'h00) begin
            tw_q     <= TW_A;
            tw_cnt_q <= 8'h00;
          end
        end
      end
      if (rd_buf)
        stat_q[`STAT_BF] <= 1'b0;
      // Buffer write loads shift register at once; collides if busy.
      if (wr_buf) begin
        if (busy_q || (is_tw && !tw_idle)) begin
          ctl_q[`CTL_WRITE_COLLISION_FLAG] <= 1'b1;
        end else begin
          buf_q  <= HWDATA[7:0];
          sr_q   <= HWDATA[7:0];
          cnt_q  <= 4'h0;
          busy_q <= is_master || is_slave;
          if (is_master) begin
            SDO <= HWDATA[7];
          end
        end
      end
      // Master: toggle the clock at each half period; shift in on the idle-to-active half, drive out on the other.
      SCK_OE_N <= !is_master;
      if (!busy_q || !is_master)
        SCK_OUT <= clock_polarity_select;
      if (half_tick) begin
        if (SCK_OUT == clock_polarity_select) begin
          SCK_OUT <= !clock_polarity_select;
          sr_q    <= {sr_q[6:0], sdi_s[1]};
          cnt_q   <= cnt_q + 4'h1;
        end else begin
          SCK_OUT <= clock_polarity_select;
          SDO     <= sr_q[7];
          if (cnt_q == `BITS_PER_BYTE) begin
            buf_q            <= sr_q;
            stat_q[`STAT_BF] <= 1'b1;
            irq_q[0]         <= 1'b1;
            busy_q           <= 1'b0;
          end
        end
      end
      // Slave: follow the synchronised external clock, even while asleep.
      if (is_slave && sel_ok && !wr_buf) begin
        if (lead_e)
          SDO <= sr_q[7];
        if (trail_e) begin
          sr_q  <= {sr_q[6:0], sdi_s[1]};
          if (cnt_q == `BITS_PER_BYTE - 4'h1) begin
            cnt_q  <= 4'h0;
            buf_q  <= {sr_q[6:0], sdi_s[1]};
            busy_q <= 1'b0;
            irq_q[0] <= 1'b1;
            if (stat_q[`STAT_BF])
              ctl_q[`CTL_OVF] <= 1'b1;
            stat_q[`STAT_BF] <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
      end
      // Two-wire sequencer: two phases per condition, then self-clear.
      if (is_tw && !sleep_q) begin
        case (tw_q)
          TW_IDLE: begin
            SCL_OE_N <= 1'b1;
            SDA_OE_N <= 1'b1;
          end
          TW_A: begin
            tw_cnt_q <= tw_cnt_q + 8'h01;
            SCL_OE_N <= (tw_op_q == 4'h0 || tw_op_q == 4'h1) ? 1'b1 : 1'b0;
            SDA_OE_N <= (tw_op_q == 4'h2) ? 1'b0 : 1'b1;
            if (tw_cnt_q == `TW_PHASE_CYC) begin
              tw_cnt_q <= 8'h00;
              tw_q     <= TW_B;
            end
          end
          TW_B: begin
            tw_cnt_q <= tw_cnt_q + 8'h01;
            SDA_OE_N <= (tw_op_q <= 4'h1) ? 1'b0 : 1'b1;
            SCL_OE_N <= 1'b1;
            if (tw_cnt_q == `TW_PHASE_CYC) begin
              tw_cnt_q <= 8'h00;
              tw_q     <= TW_ACK;
            end
          end
          TW_ACK: begin
            seq_q[`SEQ_ACK_RECEIVED_STATUS] <= sda_s[1];
            seq_q[4:0] <= 5'h00;
            irq_q[0]   <= 1'b1;
            tw_q       <= TW_IDLE;
          end
          default: tw_q <= TW_IDLE;
        endcase
      end
      // Outside two-wire mode both open-drain lines are released.
      // This also covers a sequence cut short by a disable or a mode change.
      if (!is_tw) begin
        SCL_OE_N <= 1'b1;
        SDA_OE_N <= 1'b1;
        tw_q     <= TW_IDLE;
      end
      // Sticky status clears by writing one; a same-cycle event wins.
      if (ph_sel && ph_wr && ph_adr == `OFS_IRQ_STATUS)
        irq_q <= irq_q & ~HWDATA[7:0];
      if (half_tick && SCK_OUT != clock_polarity_select && cnt_q == `BITS_PER_BYTE)
        irq_q[0] <= 1'b1;
      if (is_slave && sel_ok && !wr_buf && trail_e && cnt_q == `BITS_PER_BYTE - 4'h1)
        irq_q[0] <= 1'b1;
      if (is_tw && !sleep_q && tw_q == TW_ACK)
        irq_q[0] <= 1'b1;
      // Level interrupt follows the unmasked flags one cycle later; wake does too, but only while asleep.
      IRQ  <= |(irq_q & mask_q);
      WAKE <= sleep_q && |(irq_q & mask_q);
      if (WAKE)
        sleep_q <= 1'b0;
    end
  end
endmodule

// ---- ssp_defines.vh ----
// Register offsets, field positions, reset values and timing counts of the serial port.
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH
`define OFS_CONTROL     8'h14
`define OFS_STATUS      8'h94
`define OFS_BUFFER      8'h13
`define OFS_SEQ_CONTROL 8'h91
`define OFS_IRQ_STATUS  8'hA0
`define OFS_IRQ_MASK    8'hA4
`define OFS_SLEEP       8'hA8
`define CTL_RESET       8'h00
`define STAT_RESET      8'h00
`define CTL_WRITE_COLLISION_FLAG        7
`define CTL_OVF         6
`define CTL_EN          5
`define CTL_CKP         4
`define STAT_SMP        7
`define STAT_CKE        6
`define STAT_BF         0
`define SEQ_ACK_RECEIVED_STATUS     6
`define SEQ_ACK_SEQUENCE_REQUEST       4
`define SEQ_RECEIVE_REQUEST        3
`define SEQ_PEN         2
`define SEQ_REPEAT_START_REQUEST        1
`define SEQ_SEN         0
`define MODE_M_DIV4     4'h0
`define MODE_M_DIV16    4'h1
`define MODE_M_DIV64    4'h2
`define MODE_M_TMR      4'h3
`define MODE_S_SEL      4'h4
`define MODE_S_NOSEL    4'h5
`define MODE_TW_MASTER  4'h8
`define BITS_PER_BYTE   4'h8
`define TW_PHASE_CYC    8'h05
`endif

// ---- ssp_assertions.sv ----
// Assertions on the serial port's bus, pin and interrupt outputs.
`timescale 1ns/1ps
module ssp_checker (
  input logic        CLK,
  input logic        RST_N,
  input logic        HSEL,
  input logic [31:0] HADDR,
  input logic [1:0]  HTRANS,
  input logic        HWRITE,
  input logic [31:0] HWDATA,
  input logic        HREADY,
  input logic [31:0] HRDATA,
  input logic        SCK_OE_N,
  input logic        SDA_OUT,
  input logic        SDA_OE_N,
  input logic        SCL_OE_N,
  input logic        IRQ
);
  logic       ap_q;
  logic       wr_q;
  logic [7:0] ad_q;
  logic [7:0] ctl_q;
  logic [7:0] msk_q;
  // Track the data phase and mirror control and mask writes.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ap_q  <= 1'b0;
      wr_q  <= 1'b0;
      ad_q  <= 8'h00;
      ctl_q <= 8'h00;
      msk_q <= 8'h00;
    end else begin
      ap_q <= HSEL && HREADY && HTRANS[1];
      wr_q <= HWRITE;
      ad_q <= HADDR[7:0];
      if (ap_q && wr_q && ad_q == 8'h14) ctl_q <= HWDATA[7:0];
      if (ap_q && wr_q && ad_q == 8'hA4) msk_q <= HWDATA[7:0];
    end
  end
  // A start request reaching an enabled two-wire master, idle or not, and a read of an unused address.
  wire sen_w = ap_q && wr_q && ad_q == 8'h91 && HWDATA[0] && ctl_q[5] && ctl_q[3:0] == 4'h8;
  wire rd_un = ap_q && !wr_q && !(ad_q inside {8'h13, 8'h14, 8'h91, 8'h94, 8'hA0, 8'hA4, 8'hA8});
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_reset_idle: assert property ($rose(RST_N) |-> SCK_OE_N && SDA_OE_N && SCL_OE_N && !IRQ)
    else $error("pins driven or interrupt high after reset");
  a_off_quiet: assert property (!ctl_q[5] |=> SCK_OE_N && SCL_OE_N && SDA_OE_N)
    else $error("disabled port drives a pin");
  a_slave_sck: assert property (ctl_q[5] && ctl_q[3:2] == 2'b01 |=> SCK_OE_N)
    else $error("slave role drives the serial clock");
  a_start_cond: assert property (sen_w |-> ##[1:40] !SDA_OE_N && !SDA_OUT && SCL_OE_N)
    else $error("no start condition after start request");
  a_irq_cause: assert property ($rose(IRQ) |-> msk_q[0])
    else $error("interrupt raised while masked");
  a_unmapped_zero: assert property (rd_un |-> HRDATA == 32'h0)
    else $error("unused address reads nonzero");
  a_status_ro: assert property (ap_q && !wr_q && ad_q == 8'h94 && !ctl_q[3] |-> HRDATA[5:1] == 5'h00)
    else $error("read-only status bits set in SPI role");
  a_ctl_readback: assert property (ap_q && !wr_q && ad_q == 8'h14 |-> HRDATA[5:0] == ctl_q[5:0])
    else $error("control reads back wrong");
endmodule
bind sync_serial_module ssp_checker u_ssp_checker (.*);

// ---- spi_peer.sv ----
// Behavioural far-side SPI peer: slave to the port's clock, master for slave-role frames.
`timescale 1ns/1ps
module spi_peer (
  input  wire  SCK_OUT,
  input  wire  SDO,
  output logic SCK_IN,
  output logic SDI
);
  logic [7:0] tx = 8'hA5;
  logic [7:0] rx = 8'h00;
  initial SCK_IN = 1'b0;
  // The data line always shows the top bit of the byte being sent.
  assign SDI = tx[7];
  // Capture on the rising edge, step on the falling edge; refill bits keep changing.
  always @(posedge SCK_OUT) rx <= {rx[6:0], SDO};
  always @(negedge SCK_OUT) tx <= {tx[6:0], ~tx[0]};
  task load(input logic [7:0] v);
    tx = v;
  endtask
  // Clock one frame in at the link rate; the clock stays low between frames.
  task send(input logic [7:0] v);
    tx = v;
    #37;
    repeat (8) begin
      #400 SCK_IN = 1'b1;
      rx = {rx[6:0], SDO};
      #400 SCK_IN = 1'b0;
      tx = {tx[6:0], ~tx[0]};
    end
  endtask
endmodule

// ---- tb.sv ----
// Self-checking testbench of the synchronous serial port.
`timescale 1ns/1ps
module tb;
  logic        CLK = 0, RST_N = 0, HSEL = 0, HWRITE = 0;
  logic [1:0]  HTRANS = 2'h0;
  logic [2:0]  HSIZE = 3'h2;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, r;
  logic [7:0]  b, pb;
  wire  [31:0] HRDATA;
  wire         HREADYOUT, HRESP, SCK_IN, SCK_OUT, SCK_OE_N, SDI, SDO, SDA_OUT, SDA_OE_N, SCL_OUT, SCL_OE_N, IRQ, WAKE;
  int          errors = 0, check_count = 0, cyc = 0, i, k;
  wire         SDA_IN = SDA_OE_N | SDA_OUT;
  always #50 CLK = ~CLK;
  sync_serial_module u_sync_serial_module (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SCK_IN(SCK_IN), .SCK_OUT(SCK_OUT), .SCK_OE_N(SCK_OE_N), .SDI(SDI),
    .SDO(SDO), .SEL_N(1'b1), .TMR_TICK(1'b0), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
    .SCL_OUT(SCL_OUT), .SCL_OE_N(SCL_OE_N), .IRQ(IRQ), .WAKE(WAKE));
  spi_peer u_spi_peer (.SCK_OUT(SCK_OUT), .SDO(SDO), .SCK_IN(SCK_IN), .SDI(SDI));
  // Print the counts and the verdict, then end the run.
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single-word transfer: address phase, then data phase; read data kept in r.
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    HTRANS <= 2'h2;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task wirq;
    for (i = 0; i < 2000 && IRQ !== 1'b1; i++) @(posedge CLK);
    chk({31'h0, IRQ}, 32'h1);
  endtask
  // Hang guard: the whole run needs a few hundred cycles.
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      stop_test;
    end
  end
  initial begin
    i = $urandom(32'h22d9db0c);
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    rd(8'h14, 32'h00);
    rd(8'h94, 32'h00);
    ahb(1'b1, 8'h94, 32'hFF);
    rd(8'h94, 32'hC0);
    ahb(1'b1, 8'h40, 32'hFF);
    rd(8'h40, 32'h00);
    $display("test 1 done");
    for (k = 0; k < 4; k++) begin
      ahb(1'b1, 8'h94, k[0] ? 32'h00 : 32'h40);
      ahb(1'b1, 8'h14, k[1] ? 32'h30 : 32'h20);
      repeat (3) @(posedge CLK);
      chk({31'h0, SCK_OUT}, {31'h0, k[1]});
    end
    ahb(1'b1, 8'h94, 32'h40);
    ahb(1'b1, 8'h14, 32'h21);
    ahb(1'b1, 8'hA4, 32'h01);
    b = $urandom;
    pb = $urandom;
    u_spi_peer.load(pb);
    ahb(1'b1, 8'h13, {24'h0, b});
    ahb(1'b1, 8'h13, {24'h0, ~b});
    wirq;
    chk({24'h0, u_spi_peer.rx}, {24'h0, b});
    rd(8'h13, {24'h0, pb});
    rd(8'h14, 32'hA1);
    ahb(1'b1, 8'h14, 32'h20);
    rd(8'h14, 32'h20);
    ahb(1'b1, 8'hA0, 32'h01);
    repeat (2) @(posedge CLK);
    chk({31'h0, IRQ}, 32'h0);
    $display("test 2 done");
    ahb(1'b1, 8'h14, 32'h25);
    ahb(1'b1, 8'hA8, 32'h01);
    b = $urandom;
    u_spi_peer.send(b);
    wirq;
    chk({31'h0, WAKE}, 32'h1);
    ahb(1'b1, 8'hA8, 32'h00);
    rd(8'h13, {24'h0, b});
    ahb(1'b1, 8'hA0, 32'h01);
    $display("test 3 done");
    ahb(1'b1, 8'h14, 32'h28);
    for (k = 0; k < 2; k++) begin
      ahb(1'b1, 8'h91, 32'h1 << k);
      ahb(1'b1, 8'h91, 32'h04);
      ahb(1'b0, 8'h91, 32'h0);
      chk({31'h0, r[2]}, 32'h0);
      repeat (60) @(posedge CLK);
      ahb(1'b0, 8'h91, 32'h0);
      chk({31'h0, r[k]}, 32'h0);
    end
    $display("test 4 done");
    ahb(1'b1, 8'h14, 32'h20);
    ahb(1'b1, 8'h13, {24'h0, b});
    repeat (5) @(posedge CLK);
    RST_N <= 1'b0;
    @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    rd(8'h14, 32'h00);
    chk({31'h0, SCK_OE_N}, 32'h1);
    $display("test 5 done");
    stop_test;
  end
endmodule
